// *** hdl/rsx_exec.sv ***
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ns
`include "rsx_defs.svh"
// Behaviour
// (RQ1) rotate right one place, old bit 0 lands in bit 7, carry unused
// (RQ2) rotate decoded from upper bits 0100 00, then d, a and 8-bit address
// (RQ3) d=0 writes result to working register, d=1 back to file register
// (RQ4) a=0 uses access bank ignoring bank select, a=1 uses bank select
// (RQ5) a=0 with extended set on: address at or below 5Fh is indexed off base
// (RQ6) rotate updates only negative and zero flags
// (RQ7) set-register decoded from 0110 100, writes FFh, touches no flags
// (RQ8) fixed pattern 0003h enters sleep, core clock considered stopped
// (RQ9) sleep clears watchdog counter and postscaler, sets time-out, clears power-down
// (RQ10) watchdog wake from sleep clears the time-out bit
// (RQ11) subtract computes W minus f minus inverted carry, dest by d
// (RQ12) subtract updates negative, overflow, carry, digit carry and zero
// (RQ13) each instruction runs four phases: decode, read, process, write or sleep
module rsx_exec
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             sleep_o
);
   import rsx_pkg::*;

   rsx_state_t  state_q;
   rsx_kind_t   kind_q;
   rsx_kind_t   kind_d;
   logic [15:0] ir_q;
   logic        dst_f_q;
   logic [11:0] addr_q;
   logic [11:0] addr_d;
   logic [7:0]  opnd_q;
   logic [7:0]  res_q;
   logic        fl_n_q;
   logic        fl_ov_q;
   logic        fl_c_q;
   logic        fl_dc_q;
   logic        fl_z_q;
   logic [7:0]  w_q;
   logic [4:0]  status_q;
   logic [3:0]  bank_q;
   logic [11:0] index_q;
   logic [1:0]  ctrl_q;
   logic        to_q;
   logic        pd_q;
   logic        illegal_q;
   logic [7:0]  wdt_cnt_q;
   logic [7:0]  wdt_post_q;
   logic [11:0] maddr_q;
   logic [7:0]  mem_q [0:4095];
   logic        ack_q;
   logic [31:0] dat_q;
   logic        sleep_q;
   logic [31:0] rd_mux;
   logic [7:0]  bus_adr;
   logic        wr_en;
   logic        wr_lo;
   logic        wr_hi;
   logic        instr_wr;
   logic        wake_wr;
   logic        wdt_fire;
   logic        exec_q4;
   logic        sleep_exec;
   logic        mem_we_exec;
   logic [7:0]  f_field;

   rsx_alu_if alu_bus ();

   rsx_alu u_alu
   (
      .port_if (alu_bus.alu)
   );

   assign alu_bus.kind = kind_q;
   assign alu_bus.w    = w_q;
   assign alu_bus.f    = opnd_q;
   assign alu_bus.c_in = status_q[`RSX_ST_C];

   // writes land on the edge that samples ack, so data is stable by then
   assign bus_adr     = {wb_adr_i[7:2], 2'b00};
   assign wr_en       = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
   assign wr_lo       = wr_en && wb_sel_i[0];
   assign wr_hi       = wr_en && wb_sel_i[1];
   assign instr_wr    = wr_lo && wr_hi && (bus_adr == `RSX_OFF_INSTR);
   assign wake_wr     = wr_lo && (bus_adr == `RSX_OFF_PWR) && wb_dat_i[`RSX_PWR_WAKE];
   assign wdt_fire    = ctrl_q[`RSX_CTRL_WDT_EN] && (wdt_cnt_q == `RSX_BYTE_ONES)
                        && (wdt_post_q == `RSX_WDT_POST_LAST);
   assign exec_q4     = (state_q == RSX_ST_Q4);
   assign sleep_exec  = exec_q4 && (kind_q == RSX_K_SLEEP);
   assign mem_we_exec = exec_q4 && ((kind_q == RSX_K_SET)
                        || (((kind_q == RSX_K_ROT) || (kind_q == RSX_K_SUB)) && dst_f_q)); // see (RQ3)
   assign f_field     = ir_q[7:0];

   // opcode decode and address formation
   always_comb
   begin
      kind_d = RSX_K_NONE;
      if ((ir_q & `RSX_MASK_6) == `RSX_OP_ROT)
         kind_d = RSX_K_ROT; // see (RQ2)
      else if ((ir_q & `RSX_MASK_7) == `RSX_OP_SET)
         kind_d = RSX_K_SET; // see (RQ7)
      else if ((ir_q & `RSX_MASK_6) == `RSX_OP_SUB)
         kind_d = RSX_K_SUB; // see (RQ11)
      else if (ir_q == `RSX_OP_SLEEP)
         kind_d = RSX_K_SLEEP; // see (RQ8)
      if (ir_q[`RSX_IR_A])
         addr_d = {bank_q, f_field}; // see (RQ4)
      else if (ctrl_q[`RSX_CTRL_EXT] && (f_field <= `RSX_INDEX_LIMIT))
         addr_d = index_q + {4'h0, f_field}; // see (RQ5)
      else if (f_field < `RSX_ACC_SPLIT)
         addr_d = {`RSX_ACC_LO_BANK, f_field}; // see (RQ4)
      else
         addr_d = {`RSX_ACC_HI_BANK, f_field};
   end

   // quarter-phase sequencer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_q <= RSX_ST_IDLE;
      else if (ce_i)
      begin
         case (state_q)
            RSX_ST_IDLE:  if (instr_wr) state_q <= RSX_ST_Q1;
            RSX_ST_Q1:    state_q <= RSX_ST_Q2; // see (RQ13)
            RSX_ST_Q2:    state_q <= RSX_ST_Q3;
            RSX_ST_Q3:    state_q <= RSX_ST_Q4;
            RSX_ST_Q4:    state_q <= (kind_q == RSX_K_SLEEP) ? RSX_ST_SLEEP : RSX_ST_IDLE; // see (RQ8)
            RSX_ST_SLEEP: if (wdt_fire || wake_wr) state_q <= RSX_ST_IDLE;
            default:      state_q <= RSX_ST_IDLE;
         endcase
      end
   end

   // instruction latch, decode in q1, operand in q2, result in q3
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ir_q    <= 16'h0000;
         kind_q  <= RSX_K_NONE;
         dst_f_q <= 1'b1;
         addr_q  <= 12'h000;
         opnd_q  <= `RSX_BYTE_ZERO;
         res_q   <= `RSX_BYTE_ZERO;
         fl_n_q  <= 1'b0;
         fl_ov_q <= 1'b0;
         fl_c_q  <= 1'b0;
         fl_dc_q <= 1'b0;
         fl_z_q  <= 1'b0;
      end
      else if (ce_i)
      begin
         if ((state_q == RSX_ST_IDLE) && instr_wr)
            ir_q <= wb_dat_i[15:0];
         if (state_q == RSX_ST_Q1)
         begin
            kind_q  <= kind_d;
            dst_f_q <= ir_q[`RSX_IR_D];
            addr_q  <= addr_d;
         end
         if ((state_q == RSX_ST_Q2) && (kind_q != RSX_K_SLEEP))
            opnd_q <= mem_q[addr_q];
         if (state_q == RSX_ST_Q3)
         begin
            res_q   <= alu_bus.result;
            fl_n_q  <= alu_bus.n;
            fl_ov_q <= alu_bus.ov;
            fl_c_q  <= alu_bus.c;
            fl_dc_q <= alu_bus.dc;
            fl_z_q  <= alu_bus.z;
         end
      end
   end

   // file register memory; the executing instruction wins over a bus write
   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (mem_we_exec)
            mem_q[addr_q] <= res_q; // see (RQ3)
         else if (wr_lo && (bus_adr == `RSX_OFF_MDATA))
            mem_q[maddr_q] <= wb_dat_i[7:0];
      end
   end

   // working register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         w_q <= `RSX_BYTE_ZERO;
      else if (ce_i)
      begin
         if (exec_q4 && !dst_f_q && ((kind_q == RSX_K_ROT) || (kind_q == RSX_K_SUB)))
            w_q <= res_q; // see (RQ3)
         else if (wr_lo && (bus_adr == `RSX_OFF_WREG))
            w_q <= wb_dat_i[7:0];
      end
   end

   // status flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_q <= `RSX_STATUS_RST;
      else if (ce_i)
      begin
         if (exec_q4 && (kind_q == RSX_K_ROT))
         begin
            status_q[`RSX_ST_N] <= fl_n_q; // see (RQ6)
            status_q[`RSX_ST_Z] <= fl_z_q;
         end
         else if (exec_q4 && (kind_q == RSX_K_SUB))
         begin
            status_q[`RSX_ST_N]  <= fl_n_q; // see (RQ12)
            status_q[`RSX_ST_OV] <= fl_ov_q;
            status_q[`RSX_ST_C]  <= fl_c_q;
            status_q[`RSX_ST_DC] <= fl_dc_q;
            status_q[`RSX_ST_Z]  <= fl_z_q;
         end
         else if (wr_lo && (bus_adr == `RSX_OFF_STATUS))
            status_q <= wb_dat_i[4:0];
      end
   end

   // software-owned configuration
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_q  <= `RSX_CTRL_RST;
         bank_q  <= 4'h0;
         index_q <= 12'h000;
         maddr_q <= 12'h000;
      end
      else if (ce_i)
      begin
         if (wr_lo && (bus_adr == `RSX_OFF_CTRL))
            ctrl_q <= wb_dat_i[1:0];
         if (wr_lo && (bus_adr == `RSX_OFF_BANK))
            bank_q <= wb_dat_i[3:0];
         if (wr_lo && (bus_adr == `RSX_OFF_INDEX))
            index_q[7:0] <= wb_dat_i[7:0];
         if (wr_hi && (bus_adr == `RSX_OFF_INDEX))
            index_q[11:8] <= wb_dat_i[11:8];
         if (wr_lo && (bus_adr == `RSX_OFF_MADDR))
            maddr_q[7:0] <= wb_dat_i[7:0];
         if (wr_hi && (bus_adr == `RSX_OFF_MADDR))
            maddr_q[11:8] <= wb_dat_i[11:8];
      end
   end

   // power status: both bits come up set, as after power-on
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         to_q      <= 1'b1;
         pd_q      <= 1'b1;
         illegal_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (sleep_exec)
         begin
            to_q <= 1'b1; // see (RQ9)
            pd_q <= 1'b0;
         end
         else if (wdt_fire)
            to_q <= 1'b0; // see (RQ10)
         // a decode fault beats a clear in the same cycle
         if ((state_q == RSX_ST_Q1) && (kind_d == RSX_K_NONE))
            illegal_q <= 1'b1;
         else if (wr_lo && (bus_adr == `RSX_OFF_PWR) && wb_dat_i[`RSX_PWR_ILLEGAL])
            illegal_q <= 1'b0;
      end
   end

   // watchdog counter with postscaler; counts through sleep so it can wake the core
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wdt_cnt_q  <= `RSX_BYTE_ZERO;
         wdt_post_q <= `RSX_BYTE_ZERO;
      end
      else if (ce_i)
      begin
         if (sleep_exec)
         begin
            wdt_cnt_q  <= `RSX_BYTE_ZERO; // see (RQ9)
            wdt_post_q <= `RSX_BYTE_ZERO;
         end
         else if (ctrl_q[`RSX_CTRL_WDT_EN])
         begin
            wdt_cnt_q <= wdt_cnt_q + 8'h01;
            if (wdt_fire)
               wdt_post_q <= `RSX_BYTE_ZERO;
            else if (wdt_cnt_q == `RSX_BYTE_ONES)
               wdt_post_q <= wdt_post_q + 8'h01;
         end
      end
   end

   // sleep indication, registered so the output is a flop
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sleep_q <= 1'b0;
      else if (ce_i)
      begin
         if (sleep_exec)
            sleep_q <= 1'b1; // see (RQ8)
         else if ((state_q == RSX_ST_SLEEP) && (wdt_fire || wake_wr))
            sleep_q <= 1'b0;
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb
   begin
      rd_mux = `RSX_WORD_ZERO;
      case (bus_adr)
         `RSX_OFF_CTRL:   rd_mux[1:0]   = ctrl_q;
         `RSX_OFF_INSTR:  rd_mux[15:0]  = ir_q;
         `RSX_OFF_WREG:   rd_mux[7:0]   = w_q;
         `RSX_OFF_STATUS: rd_mux[4:0]   = status_q;
         `RSX_OFF_BANK:   rd_mux[3:0]   = bank_q;
         `RSX_OFF_INDEX:  rd_mux[11:0]  = index_q;
         `RSX_OFF_PWR:    rd_mux[4:0]   = {illegal_q, sleep_q, (state_q != RSX_ST_IDLE), pd_q, to_q};
         `RSX_OFF_WDT:    rd_mux[15:0]  = {wdt_post_q, wdt_cnt_q};
         `RSX_OFF_MADDR:  rd_mux[11:0]  = maddr_q;
         `RSX_OFF_MDATA:  rd_mux[7:0]   = mem_q[maddr_q];
         default:         rd_mux        = `RSX_WORD_ZERO;
      endcase
   end

   // wishbone classic: ack one cycle after strobe, dropped the next cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= `RSX_WORD_ZERO;
      end
      else if (ce_i)
      begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i)
            dat_q <= rd_mux;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign sleep_o  = sleep_q;

   a_rot_result: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == RSX_ST_Q3 && ce_i && kind_q == RSX_K_ROT) |=> res_q == {$past(opnd_q[0]), $past(opnd_q[7:1])})
      else $error("rotate result wrong"); // see (RQ1)

   a_rot_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == RSX_ST_Q1 && ce_i && (ir_q & `RSX_MASK_6) == `RSX_OP_ROT) |=> kind_q == RSX_K_ROT)
      else $error("rotate not decoded"); // see (RQ2)

   a_dest_work: assert property (@(posedge clk_i) disable iff (rst_i)
      (exec_q4 && ce_i && !dst_f_q && kind_q == RSX_K_SUB) |=> w_q == $past(res_q))
      else $error("working register not written"); // see (RQ3)

   a_bank_select: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == RSX_ST_Q1 && ce_i && ir_q[`RSX_IR_A]) |=> addr_q == {$past(bank_q), $past(f_field)})
      else $error("banked address wrong"); // see (RQ4)

   a_index_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == RSX_ST_Q1 && ce_i && !ir_q[`RSX_IR_A] && ctrl_q[`RSX_CTRL_EXT] && f_field <= `RSX_INDEX_LIMIT)
      |=> addr_q == $past(index_q) + {`RSX_ACC_LO_BANK, $past(f_field)})
      else $error("indexed address wrong"); // see (RQ5)

   a_rot_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      (exec_q4 && ce_i && kind_q == RSX_K_ROT) |=> $stable(status_q[`RSX_ST_C]) && $stable(status_q[`RSX_ST_DC])
      && $stable(status_q[`RSX_ST_OV]))
      else $error("rotate touched other flags"); // see (RQ6)

   a_set_ones: assert property (@(posedge clk_i) disable iff (rst_i)
      (exec_q4 && ce_i && kind_q == RSX_K_SET) |=> mem_q[$past(addr_q)] == `RSX_BYTE_ONES && $stable(status_q))
      else $error("set register failed"); // see (RQ7)

   a_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
      (sleep_exec && ce_i) |=> state_q == RSX_ST_SLEEP && sleep_q && to_q && !pd_q
      && wdt_cnt_q == `RSX_BYTE_ZERO && wdt_post_q == `RSX_BYTE_ZERO)
      else $error("sleep entry effects wrong"); // see (RQ9)

   a_wdt_wake: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == RSX_ST_SLEEP && ce_i && wdt_fire) |=> !to_q && state_q == RSX_ST_IDLE ##1 1'b1)
      else $error("watchdog wake wrong"); // see (RQ10)

   a_sub_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (exec_q4 && ce_i && kind_q == RSX_K_SUB) |=> status_q[`RSX_ST_Z] == ($past(res_q) == `RSX_BYTE_ZERO)
      && status_q[`RSX_ST_N] == $past(res_q[7]) && status_q[`RSX_ST_C] == $past(fl_c_q))
      else $error("subtract flags wrong"); // see (RQ12)

   a_phase_walk: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == RSX_ST_Q1 && ce_i) |=> state_q == RSX_ST_Q2)
      else $error("phase order broken"); // see (RQ13)

   a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (ack_q && ce_i) |=> !ack_q)
      else $error("ack held too long");
endmodule

// *** hdl/rsx_defs.svh ***
`ifndef RSX_DEFS_SVH
`define RSX_DEFS_SVH

// register byte offsets
`define RSX_OFF_CTRL        8'h00
`define RSX_OFF_INSTR       8'h04
`define RSX_OFF_WREG        8'h08
`define RSX_OFF_STATUS      8'h0C
`define RSX_OFF_BANK        8'h10
`define RSX_OFF_INDEX       8'h14
`define RSX_OFF_PWR         8'h18
`define RSX_OFF_WDT         8'h1C
`define RSX_OFF_MADDR       8'h20
`define RSX_OFF_MDATA       8'h24

// control bits
`define RSX_CTRL_EXT        0
`define RSX_CTRL_WDT_EN     1

// status flag bits
`define RSX_ST_C            0
`define RSX_ST_DC           1
`define RSX_ST_Z            2
`define RSX_ST_OV           3
`define RSX_ST_N            4

// power register bits
`define RSX_PWR_TO          0
`define RSX_PWR_PD          1
`define RSX_PWR_BUSY        2
`define RSX_PWR_SLEEP       3
`define RSX_PWR_ILLEGAL     4
`define RSX_PWR_WAKE        5

// instruction fields and encodings
`define RSX_IR_D            9
`define RSX_IR_A            8
`define RSX_MASK_6          16'hFC00
`define RSX_MASK_7          16'hFE00
`define RSX_OP_ROT          16'h4000
`define RSX_OP_SET          16'h6800
`define RSX_OP_SUB          16'h5400
`define RSX_OP_SLEEP        16'h0003
`define RSX_INDEX_LIMIT     8'h5F
`define RSX_ACC_SPLIT       8'h60
`define RSX_ACC_HI_BANK     4'hF
`define RSX_ACC_LO_BANK     4'h0

// reset values and constants
`define RSX_CTRL_RST        2'h0
`define RSX_STATUS_RST      5'h00
`define RSX_BYTE_ZERO       8'h00
`define RSX_BYTE_ONES       8'hFF
`define RSX_WDT_POST_LAST   8'h03
`define RSX_WORD_ZERO       32'h0000_0000

`endif

// *** hdl/rsx_pkg.sv ***
package rsx_pkg;

   typedef enum logic [5:0]
   {
      RSX_ST_IDLE  = 6'b00_0001,
      RSX_ST_Q1    = 6'b00_0010,
      RSX_ST_Q2    = 6'b00_0100,
      RSX_ST_Q3    = 6'b00_1000,
      RSX_ST_Q4    = 6'b01_0000,
      RSX_ST_SLEEP = 6'b10_0000
   } rsx_state_t;

   typedef enum logic [4:0]
   {
      RSX_K_NONE  = 5'b0_0001,
      RSX_K_ROT   = 5'b0_0010,
      RSX_K_SET   = 5'b0_0100,
      RSX_K_SUB   = 5'b0_1000,
      RSX_K_SLEEP = 5'b1_0000
   } rsx_kind_t;

endpackage

// *** hdl/rsx_alu_if.sv ***
`timescale 1ns/1ns
interface rsx_alu_if;
   import rsx_pkg::*;
   rsx_kind_t  kind;
   logic [7:0] w;
   logic [7:0] f;
   logic       c_in;
   logic [7:0] result;
   logic       n;
   logic       ov;
   logic       c;
   logic       dc;
   logic       z;

   modport core (output kind, w, f, c_in, input result, n, ov, c, dc, z);
   modport alu  (input kind, w, f, c_in, output result, n, ov, c, dc, z);
endinterface

// *** hdl/rsx_alu.sv ***
`timescale 1ns/1ns
`include "rsx_defs.svh"
module rsx_alu
(
   rsx_alu_if.alu port_if
);
   import rsx_pkg::*;

   logic [8:0] sum9;
   logic [4:0] sum5;

   // w - f - !c done as w + ~f + c, so carry out is the inverted borrow
   always_comb
   begin
      sum9           = {1'b0, port_if.w} + {1'b0, ~port_if.f} + {8'h00, port_if.c_in}; // see (RQ11)
      sum5           = {1'b0, port_if.w[3:0]} + {1'b0, ~port_if.f[3:0]} + {4'h0, port_if.c_in};
      port_if.result = port_if.f;
      port_if.c      = port_if.c_in;
      port_if.dc     = 1'b0;
      port_if.ov     = 1'b0;
      case (port_if.kind)
         RSX_K_ROT:
         begin
            port_if.result = {port_if.f[0], port_if.f[7:1]}; // see (RQ1)
         end
         RSX_K_SET:
         begin
            port_if.result = `RSX_BYTE_ONES; // see (RQ7)
         end
         RSX_K_SUB:
         begin
            port_if.result = sum9[7:0];
            port_if.c      = sum9[8]; // see (RQ12)
            port_if.dc     = sum5[4];
            port_if.ov     = (port_if.w[7] != port_if.f[7]) && (sum9[7] != port_if.w[7]);
         end
         default:
         begin
            port_if.result = port_if.f;
         end
      endcase
      port_if.n = port_if.result[7];
      port_if.z = (port_if.result == `RSX_BYTE_ZERO);
   end
endmodule

// *** dv/rsx_exec_tb.sv ***
`timescale 1ns/1ns
`include "rsx_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module rsx_exec_tb;
   import rsx_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i  = 1'b1;
   logic        cyc   = 1'b0;
   logic        stb   = 1'b0;
   logic        we    = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [31:0] dat   = 32'h0000_0000;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] dat_o;
   logic        ack;
   logic        slp;
   int          fails  = 0;
   int          checks = 0;

   always #20 clk_i = ~clk_i;

   rsx_exec u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
                   .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_o(slp));

   task automatic results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // classic cycle: hold everything until the edge that samples ack high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge clk_i);
      end
      `CHK("bus_ack", 1'b1, ack)
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0000_0000, q);
   endtask

   task automatic run_instr(input logic [15:0] ins);
      logic [31:0] q;
      int          n;
      n = 0;
      wr(`RSX_OFF_INSTR, {16'h0000, ins});
      q = 32'h0000_0004;
      while (q[`RSX_PWR_BUSY] !== 1'b0 && n < 20)
      begin
         rd(`RSX_OFF_PWR, q);
         n++;
      end
   endtask

   task automatic wait_sleep(input logic lvl, input int lim);
      int n;
      n = 0;
      while (slp !== lvl && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHK("sleep_o", lvl, slp)
   endtask

   initial
   begin
      #(40 * 30000);
      fails++;
      $display("[ERR] watchdog expected done seen hang");
      results();
   end

   initial
   begin
      logic [31:0] q;
      logic [15:0] ins;
      logic [11:0] addr, idx;
      logic [7:0]  f, w, v, res, ew, emem;
      logic [8:0]  r;
      logic [4:0]  r4, st, est;
      logic [3:0]  bank;
      logic        d, a, ext;
      logic [15:0] wd0;
      int          kind;
      void'($urandom(32'h07e9_c954));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`RSX_OFF_CTRL, q);
      `CHK("ctrl_rst", 2'h0, q[1:0])
      rd(`RSX_OFF_STATUS, q);
      `CHK("status_rst", 5'h00, q[4:0])
      rd(`RSX_OFF_PWR, q);
      `CHK("pwr_rst", 5'h03, q[4:0])
      rd(`RSX_OFF_WDT, q);
      `CHK("wdt_rst", 16'h0000, q[15:0])
      rd(8'hFC, q);
      `CHK("unmapped", 32'h0000_0000, q)
      for (int i = 0; i < 48; i++)
      begin
         kind = i % 3;
         d    = 1'($urandom);
         a    = 1'($urandom);
         ext  = 1'($urandom);
         f    = (i % 4 == 0) ? 8'h5F : (i % 4 == 1) ? 8'h60 : 8'($urandom);
         bank = 4'($urandom);
         idx  = 12'($urandom);
         w    = 8'($urandom);
         v    = 8'($urandom);
         st   = 5'($urandom);
         if (a)
            addr = {bank, f};
         else if (ext && f <= 8'h5F)
            addr = idx + {4'h0, f};
         else
            addr = (f < 8'h60) ? {4'h0, f} : {4'hF, f};
         wr(`RSX_OFF_CTRL, {31'h0000_0000, ext});
         wr(`RSX_OFF_BANK, {28'h000_0000, bank});
         wr(`RSX_OFF_INDEX, {20'h0_0000, idx});
         wr(`RSX_OFF_WREG, {24'h00_0000, w});
         wr(`RSX_OFF_STATUS, {27'h000_0000, st});
         wr(`RSX_OFF_MADDR, {20'h0_0000, addr});
         wr(`RSX_OFF_MDATA, {24'h00_0000, v});
         ew   = w;
         emem = v;
         est  = st;
         if (kind == 0)
         begin
            ins = 16'h4000 | {6'h00, d, a, f};
            res = {v[0], v[7:1]};
            est[`RSX_ST_N] = res[7];
            est[`RSX_ST_Z] = (res == 8'h00);
         end
         else if (kind == 1)
         begin
            ins = 16'h6800 | {7'h00, a, f};
            res = 8'hFF;
            d   = 1'b1;
         end
         else
         begin
            ins = 16'h5400 | {6'h00, d, a, f};
            r   = {1'b0, w} + {1'b0, ~v} + {8'h00, st[`RSX_ST_C]};
            r4  = {1'b0, w[3:0]} + {1'b0, ~v[3:0]} + {4'h0, st[`RSX_ST_C]};
            res = r[7:0];
            est = {res[7], (w[7] ^ v[7]) & (w[7] ^ res[7]), res == 8'h00, r4[4], r[8]};
         end
         if (d)
            emem = res;
         else
            ew = res;
         run_instr(ins);
         rd(`RSX_OFF_WREG, q);
         `CHK("wreg", ew, q[7:0])
         rd(`RSX_OFF_STATUS, q);
         `CHK("status", est, q[4:0])
         rd(`RSX_OFF_MDATA, q);
         `CHK("file_reg", emem, q[7:0])
      end
      run_instr(16'hFFFF);
      rd(`RSX_OFF_PWR, q);
      `CHK("illegal_set", 1'b1, q[`RSX_PWR_ILLEGAL])
      rd(`RSX_OFF_WREG, q);
      `CHK("illegal_wreg", ew, q[7:0])
      wr(`RSX_OFF_PWR, 32'h0000_0010);
      rd(`RSX_OFF_PWR, q);
      `CHK("illegal_clr", 1'b0, q[`RSX_PWR_ILLEGAL])
      // let the watchdog run, then freeze it so the sleep clear is visible
      wr(`RSX_OFF_CTRL, 32'h0000_0002);
      repeat (40) @(posedge clk_i);
      // enable low for ten edges: only the three enabled edges between the two captures count
      rd(`RSX_OFF_WDT, q);
      wd0 = q[15:0];
      ce_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      ce_i <= 1'b1;
      rd(`RSX_OFF_WDT, q);
      `CHK("ce_freeze", wd0 + 16'h0003, q[15:0])
      wr(`RSX_OFF_CTRL, 32'h0000_0000);
      wr(`RSX_OFF_INSTR, 32'h0000_0003);
      wait_sleep(1'b1, 20);
      rd(`RSX_OFF_PWR, q);
      `CHK("sleep_to_pd", 2'h1, q[1:0])
      rd(`RSX_OFF_WDT, q);
      `CHK("sleep_wdt", 16'h0000, q[15:0])
      // instruction writes while asleep are dropped
      wr(`RSX_OFF_INSTR, 32'h0000_4000 | {24'h00_0000, f});
      repeat (8) @(posedge clk_i);
      rd(`RSX_OFF_WREG, q);
      `CHK("asleep_wreg", ew, q[7:0])
      wr(`RSX_OFF_PWR, 32'h0000_0020);
      wait_sleep(1'b0, 20);
      rd(`RSX_OFF_PWR, q);
      `CHK("wake_to", 1'b1, q[`RSX_PWR_TO])
      wr(`RSX_OFF_CTRL, 32'h0000_0002);
      wr(`RSX_OFF_INSTR, 32'h0000_0003);
      wait_sleep(1'b1, 20);
      wait_sleep(1'b0, 1200);
      rd(`RSX_OFF_PWR, q);
      `CHK("wdt_wake_to", 1'b0, q[`RSX_PWR_TO])
      results();
   end
endmodule
